/* isr_pkg.sv */
// Shared constants and types for the SPI status and configuration register bank.
// Assumes a 25 MHz device clock and 16-bit SPI words with the address in the upper byte.
package isr_pkg;

  // Clock and timing
  localparam int CLK_HZ            = 25_000_000;
  localparam int CLK_PERIOD_NS     = 40;
  localparam int BASE_RATE_HZ      = 200;
  localparam int BASE_TICK_CYCLES  = CLK_HZ / BASE_RATE_HZ;
  localparam int DRDY_PULSE_NS     = 5000;
  localparam int DRDY_PULSE_CYCLES = (DRDY_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register addresses (7-bit, write flag stripped)
  localparam logic [6:0] ADDR_CHIP1_FAULTS = 7'h1d;
  localparam logic [6:0] ADDR_CHIP2_FAULTS = 7'h1e;
  localparam logic [6:0] ADDR_CHIP3_FAULTS = 7'h1f;
  localparam logic [6:0] ADDR_DRDY_OPTIONS = 7'h34;
  localparam logic [6:0] ADDR_CADENCE      = 7'h37;
  localparam logic [6:0] ADDR_SMOOTHING    = 7'h38;
  localparam logic [6:0] ADDR_GYRO_SPAN    = 7'h39;
  localparam logic [6:0] ADDR_HEALTH       = 7'h3c;
  localparam logic [6:0] ADDR_AXIS_MAP_HI  = 7'h74;
  localparam logic [6:0] ADDR_AXIS_MAP_LO  = 7'h75;

  // Command word layout
  localparam int CMD_WRITE_BIT = 15;
  localparam int CMD_ADDR_LSB  = 8;

  // Health flags fields
  localparam int HF_ACC_FAIL_LSB  = 13;
  localparam int HF_GYRO_FAIL_LSB = 10;
  localparam int HF_SELFTEST_BIT  = 5;
  localparam int HF_GYRO_OVR_BIT  = 4;
  localparam int HF_ACC_OVR_BIT   = 3;

  // Per-chip fault register fields
  localparam int FLT_ACC_LSB  = 0;
  localparam int FLT_GYRO_LSB = 3;

  // Data-ready options fields
  localparam int DRDY_EN_BIT  = 2;
  localparam int DRDY_POL_BIT = 1;

  // Reset values
  localparam logic [15:0] HEALTH_RESET    = 16'h0000;
  localparam logic [7:0]  DRDY_RESET      = 8'h04;
  localparam logic [7:0]  CADENCE_RESET   = 8'h01;
  localparam logic [7:0]  SMOOTHING_RESET = 8'h06;
  localparam logic [7:0]  SPAN_RESET      = 8'h02;
  localparam logic [15:0] AXIS_MAP_RESET  = 16'h0000;

  // Gyro span codes and over-range limits in 0.1 deg/s
  localparam logic [7:0]  SPAN_62   = 8'h01;
  localparam logic [7:0]  SPAN_125  = 8'h02;
  localparam logic [7:0]  SPAN_250  = 8'h04;
  localparam logic [7:0]  SPAN_500  = 8'h08;
  localparam logic [7:0]  SPAN_1000 = 8'h10;
  localparam logic [15:0] OVR_LIMIT_62   = 16'h0271;
  localparam logic [15:0] OVR_LIMIT_125  = 16'h04e2;
  localparam logic [15:0] OVR_LIMIT_250  = 16'h0898;
  localparam logic [15:0] OVR_LIMIT_500  = 16'h1130;
  localparam logic [15:0] OVR_LIMIT_1000 = 16'h19c8;

  // Width of internal counters
  localparam int BASE_CNT_W  = 24;
  localparam int PULSE_CNT_W = 8;

  // Health inputs of one redundant sensor chip
  typedef struct packed {
    logic acc_fail;
    logic gyro_fail;
    logic chip_gyro_z_fault;
    logic chip_gyro_y_fault;
    logic chip_gyro_x_fault;
    logic chip_acc_z_fault;
    logic chip_acc_y_fault;
    logic chip_acc_x_fault;
  } isr_chip_health_t;

  // One received SPI word
  typedef struct packed {
    logic        valid;
    logic [15:0] word;
  } isr_spi_word_t;

  // State of the SPI shifter
  typedef struct packed {
    logic [1:0]  cs_sync;
    logic [1:0]  sclk_sync;
    logic [1:0]  mosi_sync;
    logic        sclk_prev;
    logic [3:0]  bit_count;
    logic [15:0] rx_shift;
    logic [15:0] tx_shift;
    isr_spi_word_t rx;
    logic        miso;
    logic        miso_oe;
  } isr_spi_state_t;

  // State of the register bank
  typedef struct packed {
    logic [2:0][5:0]        faults;
    logic [15:0]            health;
    logic [2:0]             acc_use;
    logic [2:0]             gyro_use;
    logic [7:0]             drdy_opts;
    logic [7:0]             cadence;
    logic [7:0]             smoothing;
    logic [7:0]             span;
    logic [7:0]             axis_hi_pend;
    logic                   axis_pending;
    logic [15:0]            axis_map;
    logic [15:0]            tx_word;
    logic [BASE_CNT_W-1:0]  base_count;
    logic [7:0]             tick_count;
    logic [PULSE_CNT_W-1:0] pulse_count;
    logic                   drdy_level;
    logic                   sample_tick;
  } isr_main_state_t;

endpackage

/* isr_spi_shifter.sv */
// SPI slave shifter: 16-bit words, clock idles high, data driven on falling, sampled on rising.
// Assumes SCLK half period of at least four device clocks; pins are asynchronous to sys_clk_in.
`timescale 1ns/1ps
module isr_spi_shifter
  import isr_pkg::*;
(
  input  wire logic          sys_clk_in,
  input  wire logic          reset_in,
  input  wire logic          clk_en_in,
  input  wire logic          spi_cs_n_in,
  input  wire logic          spi_sclk_in,
  input  wire logic          spi_mosi_in,
  input  wire logic [15:0]   tx_word_in,
  output isr_spi_word_t      rx_out,
  output logic               spi_miso_out,
  output logic               spi_miso_oe_out
);

  isr_spi_state_t s;
  isr_spi_state_t next_s;

  // Next-state logic of the shifter
  always_comb
  begin
    next_s           = s;
    next_s.cs_sync   = {s.cs_sync[0], spi_cs_n_in};
    next_s.sclk_sync = {s.sclk_sync[0], spi_sclk_in};
    next_s.mosi_sync = {s.mosi_sync[0], spi_mosi_in};
    next_s.sclk_prev = s.sclk_sync[1];
    next_s.rx.valid  = 1'b0;
    if (s.cs_sync[1])
    begin
      // Deselected: release MISO and drop any partial word
      next_s.miso_oe   = 1'b0;
      next_s.bit_count = 4'h0;
    end
    else
    begin
      next_s.miso_oe = 1'b1;
      if (!s.sclk_prev && s.sclk_sync[1])
      begin
        // Rising edge: sample MOSI
        next_s.rx_shift = {s.rx_shift[14:0], s.mosi_sync[1]};
        if (s.bit_count == 4'hf)
        begin
          next_s.rx.valid = 1'b1;
          next_s.rx.word  = {s.rx_shift[14:0], s.mosi_sync[1]};
        end
        next_s.bit_count = s.bit_count + 4'h1;
      end
      else if (s.sclk_prev && !s.sclk_sync[1])
      begin
        // Falling edge: first of a word loads reply, others shift
        if (s.bit_count == 4'h0)
        begin
          next_s.tx_shift = tx_word_in;
          next_s.miso     = tx_word_in[15];
        end
        else
        begin
          next_s.tx_shift = {s.tx_shift[14:0], 1'b0};
          next_s.miso     = s.tx_shift[14];
        end
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      s <= '{cs_sync: 2'h3, sclk_sync: 2'h3, mosi_sync: 2'h0, sclk_prev: 1'b1, bit_count: 4'h0,
             rx_shift: 16'h0000, tx_shift: 16'h0000, rx: '0, miso: 1'b0, miso_oe: 1'b0};
    end
    else if (clk_en_in)
    begin
      s <= next_s;
    end
  end

  assign rx_out          = s.rx;
  assign spi_miso_out    = s.miso;
  assign spi_miso_oe_out = s.miso_oe;

endmodule // isr_spi_shifter

/* isr_regs_top.sv */
// Status and configuration register bank of a triple-redundant inertial unit, reached over SPI.
// Assumes fault, self-test, over-range and rate magnitude inputs come from logic on sys_clk_in.
`timescale 1ns/1ps

module isr_regs_top
  import isr_pkg::*;
#(
  parameter int BASE_TICK_CYCLES_P = BASE_TICK_CYCLES
)
(
  input  wire logic                  sys_clk_in,
  input  wire logic                  reset_in,
  input  wire logic                  clk_en_in,
  input  wire logic                  spi_cs_n_in,
  input  wire logic                  spi_sclk_in,
  input  wire logic                  spi_mosi_in,
  output logic                       spi_miso_out,
  output logic                       spi_miso_oe_out,
  input  wire isr_chip_health_t [2:0] chip_health_in,
  input  wire logic                  self_test_fail_in,
  input  wire logic                  acc_over_range_in,
  input  wire logic [15:0]           gyro_rate_mag_in,
  output logic                       data_ready_out,
  output logic                       sample_tick_out,
  output logic [2:0]                 acc_use_mask_out,
  output logic [2:0]                 gyro_use_mask_out,
  output logic [7:0]                 output_cadence_setting_out,
  output logic [7:0]                 smoothing_out,
  output logic [7:0]                 gyro_span_select_out,
  output logic [15:0]                axis_map_out
);

  // Elaboration checks on the base tick
  if (BASE_TICK_CYCLES_P < 2 || BASE_TICK_CYCLES_P >= (1 << BASE_CNT_W))
  begin : g_bad_base
    $error("BASE_TICK_CYCLES_P out of range");
  end
  if (DRDY_PULSE_CYCLES >= BASE_TICK_CYCLES_P || DRDY_PULSE_CYCLES >= (1 << PULSE_CNT_W))
  begin : g_bad_pulse
    $error("Data-ready pulse does not fit the base period");
  end

  // Last base count, pulse length
  localparam logic [BASE_CNT_W-1:0]  BASE_LAST  = BASE_CNT_W'(BASE_TICK_CYCLES_P - 1);
  localparam logic [PULSE_CNT_W-1:0] PULSE_LEN  = PULSE_CNT_W'(DRDY_PULSE_CYCLES);

  // Bank state and received word
  isr_main_state_t s;
  isr_main_state_t next_s;
  isr_spi_word_t   rx;

  // Base ticks per data-ready event for a cadence code; zero means suppressed
  function automatic logic [7:0] cadence_divisor(input logic [7:0] code);
    case (code)
      8'h01:        cadence_divisor = 8'h01;
      8'h02:        cadence_divisor = 8'h02;
      8'h03:        cadence_divisor = 8'h04;
      8'h04:        cadence_divisor = 8'h08;
      8'h05:        cadence_divisor = 8'h0a;
      8'h06:        cadence_divisor = 8'h14;
      8'h07:        cadence_divisor = 8'h28;
      8'h08:        cadence_divisor = 8'h32;
      8'h09:        cadence_divisor = 8'h64;
      8'h0a, 8'h10: cadence_divisor = 8'hc8;
      default:      cadence_divisor = 8'h00;
    endcase
  endfunction

  // Over-range limit for a gyro span code
  function automatic logic [15:0] span_limit(input logic [7:0] code);
    case (code)
      SPAN_62:   span_limit = OVR_LIMIT_62;
      SPAN_250:  span_limit = OVR_LIMIT_250;
      SPAN_500:  span_limit = OVR_LIMIT_500;
      SPAN_1000: span_limit = OVR_LIMIT_1000;
      default:   span_limit = OVR_LIMIT_125;
    endcase
  endfunction

  // True for a span code the unit supports
  function automatic logic span_valid(input logic [7:0] code);
    span_valid = (code == SPAN_62) || (code == SPAN_125) || (code == SPAN_250) ||
                 (code == SPAN_500) || (code == SPAN_1000);
  endfunction

  // Content of one byte register; unmapped bytes read zero
  function automatic logic [7:0] reg_byte(input logic [6:0] addr, input isr_main_state_t st);
    case (addr)
      ADDR_DRDY_OPTIONS: reg_byte = st.drdy_opts;
      ADDR_CADENCE:      reg_byte = st.cadence;
      ADDR_SMOOTHING:    reg_byte = st.smoothing;
      ADDR_GYRO_SPAN:    reg_byte = st.span;
      default:           reg_byte = 8'h00;
    endcase
  endfunction

  // Reply word for a read command
  function automatic logic [15:0] read_word(input logic [6:0] addr, input isr_main_state_t st);
    case (addr)
      ADDR_CHIP1_FAULTS: read_word = {10'h000, st.faults[0]};
      ADDR_CHIP2_FAULTS: read_word = {10'h000, st.faults[1]};
      ADDR_CHIP3_FAULTS: read_word = {10'h000, st.faults[2]};
      ADDR_HEALTH:       read_word = st.health;
      ADDR_AXIS_MAP_HI:  read_word = st.axis_map;
      default:           read_word = {reg_byte(addr + 7'h01, st), reg_byte(addr, st)};
    endcase
  endfunction

  // SPI pins and word framing
  isr_spi_shifter u_spi (
    .sys_clk_in      (sys_clk_in),
    .reset_in        (reset_in),
    .clk_en_in       (clk_en_in),
    .spi_cs_n_in     (spi_cs_n_in),
    .spi_sclk_in     (spi_sclk_in),
    .spi_mosi_in     (spi_mosi_in),
    .tx_word_in      (s.tx_word),
    .rx_out          (rx),
    .spi_miso_out    (spi_miso_out),
    .spi_miso_oe_out (spi_miso_oe_out)
  );

  // Next-state logic of the register bank
  always_comb
  begin
    // Command fields, working values
    logic [6:0]  cmd_addr;
    logic [7:0]  cmd_data;
    logic        cmd_write;
    logic [2:0]  acc_failed;
    logic [2:0]  gyro_failed;
    logic        base_tick;
    logic        cadence_tick;
    logic [7:0]  divisor;
    logic        drdy_active;

    next_s      = s;
    cmd_addr    = rx.word[CMD_WRITE_BIT-1:CMD_ADDR_LSB];
    cmd_data    = rx.word[CMD_ADDR_LSB-1:0];
    cmd_write   = rx.word[CMD_WRITE_BIT];
    acc_failed  = 3'h0;
    gyro_failed = 3'h0;
    base_tick   = 1'b0;
    cadence_tick = 1'b0;
    divisor     = 8'h00;
    drdy_active = 1'b0;

    // Per-chip fault words; a failed sensor type drops all its axes
    // Chip c+1 sits at index c
    for (int c = 0; c < 3; c++)
    begin
      acc_failed[c]  = chip_health_in[c].acc_fail | chip_health_in[c].chip_acc_x_fault |
                       chip_health_in[c].chip_acc_y_fault | chip_health_in[c].chip_acc_z_fault;
      gyro_failed[c] = chip_health_in[c].gyro_fail | chip_health_in[c].chip_gyro_x_fault |
                       chip_health_in[c].chip_gyro_y_fault | chip_health_in[c].chip_gyro_z_fault;
      next_s.faults[c][FLT_ACC_LSB +: 3] =
        {chip_health_in[c].chip_acc_z_fault, chip_health_in[c].chip_acc_y_fault,
         chip_health_in[c].chip_acc_x_fault} | {3{chip_health_in[c].acc_fail}};
      next_s.faults[c][FLT_GYRO_LSB +: 3] =
        {chip_health_in[c].chip_gyro_z_fault, chip_health_in[c].chip_gyro_y_fault,
         chip_health_in[c].chip_gyro_x_fault} | {3{chip_health_in[c].gyro_fail}};
    end

    // Combining masks: each sensor type excludes only its own failed chips
    next_s.acc_use  = ~acc_failed;
    next_s.gyro_use = ~gyro_failed;

    // Health flags word; reserved and unused bits stay zero
    // Live levels, not sticky
    next_s.health                              = 16'h0000;
    next_s.health[HF_ACC_FAIL_LSB +: 3]        = acc_failed;
    next_s.health[HF_GYRO_FAIL_LSB +: 3]       = gyro_failed;
    next_s.health[HF_SELFTEST_BIT]             = self_test_fail_in;
    next_s.health[HF_GYRO_OVR_BIT]             = gyro_rate_mag_in > span_limit(s.span);
    next_s.health[HF_ACC_OVR_BIT]              = acc_over_range_in;

    // Command decode
    // Word framed by the shifter
    if (rx.valid)
    begin
      if (cmd_write)
      begin
        // One byte per write command; any write breaks a pending axis-map pair
        next_s.axis_pending = 1'b0;
        case (cmd_addr)
          ADDR_DRDY_OPTIONS:
          begin
            // Keep enable, polarity only
            next_s.drdy_opts                = 8'h00;
            next_s.drdy_opts[DRDY_EN_BIT]   = cmd_data[DRDY_EN_BIT];
            next_s.drdy_opts[DRDY_POL_BIT]  = cmd_data[DRDY_POL_BIT];
          end
          ADDR_CADENCE:
          begin
            // Restarts the divider unless a base tick in the same cycle advances it
            next_s.cadence    = cmd_data;
            next_s.tick_count = 8'h00;
          end
          ADDR_SMOOTHING:
          begin
            next_s.smoothing = cmd_data;
          end
          ADDR_GYRO_SPAN:
          begin
            // Unknown span codes dropped
            if (span_valid(cmd_data))
            begin
              next_s.span = cmd_data;
            end
          end
          ADDR_AXIS_MAP_HI:
          begin
            // Waits for the low byte
            next_s.axis_hi_pend = cmd_data;
            next_s.axis_pending = 1'b1;
          end
          ADDR_AXIS_MAP_LO:
          begin
            // Low byte only takes effect if no write and no 0x74 read came after the high byte
            if (s.axis_pending)
            begin
              next_s.axis_map = {s.axis_hi_pend, cmd_data};
            end
          end
          default:
          begin
            // Unlisted address: no effect beyond breaking a pending axis-map pair
            next_s.axis_pending = 1'b0;
          end
        endcase
      end
      else
      begin
        // Read: reply goes out in the next word; reading 0x74 cancels a pending pair
        next_s.tx_word = read_word(cmd_addr, s);
        if (cmd_addr == ADDR_AXIS_MAP_HI)
        begin
          next_s.axis_pending = 1'b0;
        end
      end
    end

    // 200 Hz base tick
    // Free running from reset
    base_tick = (s.base_count == BASE_LAST);
    if (base_tick)
    begin
      next_s.base_count = '0;
    end
    else
    begin
      next_s.base_count = s.base_count + BASE_CNT_W'(1);
    end

    // Cadence divider on top of the base tick
    // Divisor zero means no ticks
    divisor      = cadence_divisor(s.cadence);
    cadence_tick = 1'b0;
    if (base_tick && (divisor != 8'h00))
    begin
      if (s.tick_count + 8'h01 >= divisor)
      begin
        cadence_tick      = 1'b1;
        next_s.tick_count = 8'h00;
      end
      else
      begin
        next_s.tick_count = s.tick_count + 8'h01;
      end
    end
    next_s.sample_tick = cadence_tick;

    // Data-ready pulse length
    // Reloaded by each cadence tick
    if (cadence_tick)
    begin
      next_s.pulse_count = PULSE_LEN;
    end
    else if (s.pulse_count != '0)
    begin
      next_s.pulse_count = s.pulse_count - PULSE_CNT_W'(1);
    end
    drdy_active = (next_s.pulse_count != '0);

    // Pin level: disabled pin rests at its inactive level
    next_s.drdy_level = (next_s.drdy_opts[DRDY_EN_BIT] && drdy_active) ?
                        next_s.drdy_opts[DRDY_POL_BIT] :
                        ~next_s.drdy_opts[DRDY_POL_BIT];
  end

  // State register with reset defaults and clock enable
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      // Unnamed fields clear to zero
      s              <= '0;
      s.health       <= HEALTH_RESET;
      s.acc_use      <= 3'h7;
      s.gyro_use     <= 3'h7;
      s.drdy_opts    <= DRDY_RESET;
      s.cadence      <= CADENCE_RESET;
      s.smoothing    <= SMOOTHING_RESET;
      s.span         <= SPAN_RESET;
      s.axis_map     <= AXIS_MAP_RESET;
      s.drdy_level   <= 1'b1;
    end
    else if (clk_en_in)
    begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register
  assign data_ready_out             = s.drdy_level;
  assign sample_tick_out            = s.sample_tick;
  assign acc_use_mask_out           = s.acc_use;
  assign gyro_use_mask_out          = s.gyro_use;
  assign output_cadence_setting_out = s.cadence;
  assign smoothing_out              = s.smoothing;
  assign gyro_span_select_out       = s.span;
  assign axis_map_out               = s.axis_map;

endmodule // isr_regs_top

/* isr_regs_top_assertions.sv */
// Checker on the register bank ports: use masks, tick spacing, data-ready pin, MISO enable.
// Assumes it is bound to isr_regs_top and shares its tick parameter.
`timescale 1ns/1ps
module isr_chk
  import isr_pkg::*;
#(
  parameter int BASE_TICK_CYCLES_P = 200
)
(
  input wire logic                   sys_clk_in,
  input wire logic                   reset_in,
  input wire logic                   clk_en_in,
  input wire logic                   spi_cs_n_in,
  input wire isr_chip_health_t [2:0] chip_health_in,
  input wire logic                   spi_miso_oe_out,
  input wire logic                   data_ready_out,
  input wire logic                   sample_tick_out,
  input wire logic [2:0]             acc_use_mask_out,
  input wire logic [2:0]             gyro_use_mask_out,
  input wire logic [7:0]             output_cadence_setting_out
);
  logic [2:0]  acc_bad;
  logic [2:0]  gyro_bad;
  logic [31:0] gap;
  logic        gap_ok;

  // Type failure per chip: fail flag or any axis of that type
  always_comb
  begin
    for (int c = 0; c < 3; c++)
    begin
      acc_bad[c]  = chip_health_in[c].acc_fail | (|chip_health_in[c][2:0]);
      gyro_bad[c] = chip_health_in[c].gyro_fail | (|chip_health_in[c][5:3]);
    end
  end

  // Enabled cycles since the last tick, void after a cadence change
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in || $changed(output_cadence_setting_out))
    begin
      gap    <= '0;
      gap_ok <= 1'b0;
    end
    else if (clk_en_in)
    begin
      gap    <= sample_tick_out ? 32'h1 : gap + 32'h1;
      gap_ok <= gap_ok | sample_tick_out;
    end
  end

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);

  sequence s_drdy_hold;
    $stable(data_ready_out) [*4];
  endsequence
  sequence s_cs_idle;
    (spi_cs_n_in && clk_en_in) [*4];
  endsequence

  property p_acc_mask;
    clk_en_in |=> acc_use_mask_out == ~$past(acc_bad);
  endproperty
  a_acc_mask: assert property (p_acc_mask) else $error("acc mask wrong");
  property p_gyro_mask;
    clk_en_in |=> gyro_use_mask_out == ~$past(gyro_bad);
  endproperty
  a_gyro_mask: assert property (p_gyro_mask) else $error("gyro mask wrong");
  property p_tick_pulse;
    sample_tick_out && clk_en_in |=> !sample_tick_out;
  endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("tick too long");
  property p_tick_gap;
    sample_tick_out && gap_ok && output_cadence_setting_out == 8'h01 |-> gap == 32'(BASE_TICK_CYCLES_P);
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick spacing wrong");
  property p_tick_off;
    output_cadence_setting_out == 8'h00 && $past(output_cadence_setting_out) == 8'h00 |-> !sample_tick_out;
  endproperty
  a_tick_off: assert property (p_tick_off) else $error("tick while off");
  property p_drdy_hold;
    sample_tick_out && clk_en_in && spi_cs_n_in |=> s_drdy_hold;
  endproperty
  a_drdy_hold: assert property (p_drdy_hold) else $error("pin moved in pulse");
  property p_oe_idle;
    s_cs_idle |-> !spi_miso_oe_out;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("miso driven idle");
  property p_reset_out;
    disable iff (1'b0) reset_in |=> !sample_tick_out && data_ready_out && acc_use_mask_out == 3'h7;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("reset outputs wrong");
endmodule // isr_chk

bind isr_regs_top isr_chk #(.BASE_TICK_CYCLES_P(BASE_TICK_CYCLES_P)) u_chk
(
  .sys_clk_in                (sys_clk_in),
  .reset_in                  (reset_in),
  .clk_en_in                 (clk_en_in),
  .spi_cs_n_in               (spi_cs_n_in),
  .chip_health_in            (chip_health_in),
  .spi_miso_oe_out           (spi_miso_oe_out),
  .data_ready_out            (data_ready_out),
  .sample_tick_out           (sample_tick_out),
  .acc_use_mask_out          (acc_use_mask_out),
  .gyro_use_mask_out         (gyro_use_mask_out),
  .output_cadence_setting_out(output_cadence_setting_out)
);

/* isr_spi_master.sv */
// SPI master model: 16-bit mode 3 frames, clock idles high.
// Assumes a 2-flop synchronised device; half period of 5 device clocks.
`timescale 1ns/1ps
module isr_spi_master
(
  input  wire logic sys_clk_in,
  input  wire logic spi_miso_in,
  output logic      spi_cs_n_out,
  output logic      spi_sclk_out,
  output logic      spi_mosi_out
);
  // Idle bus
  initial
  begin
    spi_cs_n_out = 1'b1;
    spi_sclk_out = 1'b1;
    spi_mosi_out = 1'b0;
  end

  // One frame, MSB first; data out on falling, sampled late in high phase
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    @(posedge sys_clk_in);
    spi_cs_n_out <= 1'b0;
    repeat (6) @(posedge sys_clk_in);
    for (int i = 15; i >= 0; i--)
    begin
      spi_sclk_out <= 1'b0;
      spi_mosi_out <= tx[i];
      repeat (5) @(posedge sys_clk_in);
      spi_sclk_out <= 1'b1;
      repeat (5) @(posedge sys_clk_in);
      rx[i] = spi_miso_in;
    end
    repeat (6) @(posedge sys_clk_in);
    spi_cs_n_out <= 1'b1;
    spi_mosi_out <= ~spi_mosi_out; // Released line does not hold its value
    repeat (6) @(posedge sys_clk_in);
  endtask

  // Write: flagged address and a single data byte
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [15:0] r;
    xfer({1'b1, a, d}, r);
  endtask

  // Read: command word, reply rides on the next word
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    logic [15:0] r;
    xfer({1'b0, a, 8'h00}, r);
    xfer(16'h0000, d);
  endtask
endmodule // isr_spi_master

/* isr_regs_top_tb_top.sv */
// Testbench for the register bank: SPI register traffic and data-ready pin checks.
// Assumes isr_spi_master as the far side and the bound checker.
`timescale 1ns/1ps
module isr_regs_top_tb_top
  import isr_pkg::*;
();
  logic                   clk;
  logic                   rst;
  logic                   en;
  logic                   cs_n;
  logic                   sclk;
  logic                   mosi;
  logic                   miso;
  logic                   miso_oe;
  logic                   st_fail;
  logic                   acc_ovr;
  logic                   drdy;
  logic                   tick;
  logic [15:0]            mag;
  logic [15:0]            amap;
  logic [7:0]             smo;
  logic [7:0]             spn;
  logic [15:0]            v;
  isr_chip_health_t [2:0] hv;
  int                     err_count;
  int                     comparisons;

  isr_regs_top #(.BASE_TICK_CYCLES_P(200)) DUT
  (
    .sys_clk_in                (clk),
    .reset_in                  (rst),
    .clk_en_in                 (en),
    .spi_cs_n_in               (cs_n),
    .spi_sclk_in               (sclk),
    .spi_mosi_in               (mosi),
    .spi_miso_out              (miso),
    .spi_miso_oe_out           (miso_oe),
    .chip_health_in            (hv),
    .self_test_fail_in         (st_fail),
    .acc_over_range_in         (acc_ovr),
    .gyro_rate_mag_in          (mag),
    .data_ready_out            (drdy),
    .sample_tick_out           (tick),
    .acc_use_mask_out          (),
    .gyro_use_mask_out         (),
    .output_cadence_setting_out(),
    .smoothing_out             (smo),
    .gyro_span_select_out      (spn),
    .axis_map_out              (amap)
  );

  isr_spi_master m
  (
    .sys_clk_in  (clk),
    .spi_miso_in (miso_oe ? miso : 1'bz),
    .spi_cs_n_out(cs_n),
    .spi_sclk_out(sclk),
    .spi_mosi_out(mosi)
  );

  // 25 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      $display("Error %s exp %h got %h", n, e, g);
      err_count++;
    end
  endtask

  task automatic rc(input logic [6:0] a, input logic [15:0] e);
    m.rd(a, v);
    chk($sformatf("reg %h", a), e, v);
  endtask

  // Pin level at the next tick, then after the pulse
  task automatic at_tick(input logic act, input logic idle);
    for (int n = 0; n < 600 && tick !== 1'b1; n++)
      @(posedge clk);
    chk("tick", 16'h0001, {15'h0, tick});
    chk("drdy", {15'h0, act}, {15'h0, drdy});
    repeat (DRDY_PULSE_CYCLES + 5) @(posedge clk);
    chk("drdy idle", {15'h0, idle}, {15'h0, drdy});
  endtask

  task automatic test_done;
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog, well beyond the expected run of some 10000 cycles
  initial
  begin
    repeat (40000) @(posedge clk);
    err_count++;
    test_done;
  end

  // Test sequence
  initial
  begin
    rst = 1'b1;
    en = 1'b1;
    hv = '0;
    st_fail = 1'b0;
    acc_ovr = 1'b0;
    mag = 16'h0000;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    rc(7'h3c, 16'h0000);
    rc(7'h34, 16'h0004);
    rc(7'h38, 16'h0206);
    rc(7'h1d, 16'h0000);
    rc(7'h50, 16'h0000);
    at_tick(1'b0, 1'b1);
    $display("test defaults done");
    hv <= {8'h40, 8'h00, 8'h80};
    st_fail <= 1'b1;
    acc_ovr <= 1'b1;
    mag <= 16'h04e3;
    rc(7'h3c, 16'h3038);
    hv <= {8'h80, 8'hc0, 8'h40};
    st_fail <= 1'b0;
    acc_ovr <= 1'b0;
    mag <= 16'h04e2;
    en <= 1'b0;
    repeat (3) @(posedge clk);
    en <= 1'b1;
    rc(7'h3c, 16'hcc00);
    hv <= {8'h08, 8'h02, 8'h21};
    rc(7'h3c, 16'h7400);
    for (int i = 0; i < 3; i++)
      rc(7'(7'h1d + i), {10'h0, hv[i][5:0]});
    $display("test health done");
    m.xfer(16'hb406, v);
    rc(7'h34, 16'h0006);
    at_tick(1'b1, 1'b0);
    m.wr(7'h34, 8'hff);
    rc(7'h34, 16'h0006);
    m.wr(7'h34, 8'h02);
    at_tick(1'b0, 1'b0);
    m.wr(7'h34, 8'h04);
    m.wr(7'h37, 8'h02);
    m.wr(7'h38, 8'h40);
    m.wr(7'h39, 8'h04);
    m.wr(7'h39, 8'h03);
    rc(7'h37, 16'h4002);
    rc(7'h38, 16'h0440);
    chk("smoothing", 16'h0040, {8'h0, smo});
    chk("span", 16'h0004, {8'h0, spn});
    hv <= '0;
    mag <= 16'h0899;
    rc(7'h3c, 16'h0010);
    m.wr(7'h74, 8'h01);
    m.wr(7'h75, 8'h11);
    m.wr(7'h75, 8'h22);
    rc(7'h74, 16'h0111);
    chk("axis map", 16'h0111, amap);
    m.wr(7'h37, 8'h00);
    repeat (450) @(posedge clk);
    m.wr(7'h37, 8'h01);
    at_tick(1'b0, 1'b1);
    $display("test config done");
    test_done;
  end
endmodule // isr_regs_top_tb_top
